// ---- rtl/eip_pkg.sv ----
package eip_pkg;

    // Bus geometry
    localparam int          ADDR_W        = 12;
    localparam int          IDX_W         = 10;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;
    localparam int          NUM_SRC       = 7;
    localparam int          SRC_ID_W      = 3;

    // Register indices (byte address is four times the index)
    localparam logic [9:0]  IDX_PENDING   = 10'h091;
    localparam logic [9:0]  IDX_CONTROL   = 10'h0d8;
    localparam logic [9:0]  IDX_ENABLE    = 10'h0e8;
    localparam logic [9:0]  IDX_PRIORITY  = 10'h0f8;
    localparam logic [9:0]  IDX_AUX_PEND  = 10'h0a0;
    localparam logic [9:0]  IDX_IRQ_STAT  = 10'h0b0;
    localparam logic [9:0]  IDX_IRQ_MASK  = 10'h0b4;

    // Source positions in enable, priority, status and mask layout
    localparam int          SRC_VOICE     = 6;
    localparam int          SRC_SPI       = 5;
    localparam int          SRC_SLEEP     = 4;
    localparam int          SRC_TIMER3    = 3;
    localparam int          SRC_CIPHER    = 2;
    localparam int          SRC_TIMER2    = 1;
    localparam int          SRC_RADIO     = 0;

    // Flag positions in the pending, control and auxiliary registers
    localparam int          PEND_TIMER3   = 7;
    localparam int          PEND_CIPHER   = 6;
    localparam int          PEND_TIMER2   = 5;
    localparam int          PEND_RADIO    = 4;
    localparam int          CTL_SLEEP     = 3;
    localparam int          AUX_VOICE     = 1;
    localparam int          AUX_SPI       = 0;

    // Implemented bits; all others read zero
    localparam logic [7:0]  ENABLE_MASK   = 8'h7f;
    localparam logic [7:0]  PRIORITY_MASK = 8'h7f;
    localparam logic [7:0]  PENDING_MASK  = 8'hf0;
    localparam logic [7:0]  CONTROL_MASK  = 8'h08;
    localparam logic [7:0]  AUX_MASK      = 8'h03;
    localparam logic [7:0]  IRQ_MASK_BITS = 8'h7f;

    // Reset values
    localparam logic [7:0]  ENABLE_RST    = 8'h00;
    localparam logic [7:0]  PRIORITY_RST  = 8'h00;
    localparam logic [7:0]  PENDING_RST   = 8'h00;
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic [7:0]  AUX_RST       = 8'h00;
    localparam logic [7:0]  IRQ_STAT_RST  = 8'h00;
    localparam logic [7:0]  IRQ_MASK_RST  = 8'h00;

endpackage

// ---- rtl/eip_arbiter.sv ----
`timescale 1ns/1ps
module eip_arbiter #(
    parameter int NUM_SRC  = eip_pkg::NUM_SRC,
    parameter int SRC_ID_W = eip_pkg::SRC_ID_W
) (
    // Per-source state
    input  wire logic [NUM_SRC-1:0]  pending,
    input  wire logic [NUM_SRC-1:0]  enable,
    input  wire logic [NUM_SRC-1:0]  priority_high,
    // Request towards the core
    output logic                     req,
    output logic                     req_high,
    output logic [SRC_ID_W-1:0]      req_src
);

    logic [NUM_SRC-1:0] active;
    logic [NUM_SRC-1:0] active_high;

    // Lowest set bit wins inside one priority level
    function automatic logic [SRC_ID_W-1:0] pick_lowest(input logic [NUM_SRC-1:0] vec);
        logic [SRC_ID_W-1:0] id;
        id = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                id = SRC_ID_W'(i);
            end
        end
        return id;
    endfunction

    always_comb begin
        active      = pending & enable;
        active_high = active & priority_high;
        req         = |active;
        req_high    = |active_high;
        if (req_high) begin
            req_src = pick_lowest(active_high);
        end else begin
            req_src = pick_lowest(active);
        end
    end

endmodule

// ---- rtl/eip_ctrl.sv ----
// How it works
// - The enable register holds one read-write enable bit per source, voice at bit 6 down to radio at bit 0, all reset to zero.
// - The priority register at index 0xf8 holds one read-write priority bit per source in the enable order, bit 7 reserved, reset zero.
// - A source with priority bit one is arbitrated as high level, with zero as low level.
// - The pending register at index 0x91 has a flag set to one whenever the matching source event occurs.
// - Pending bits 7 to 4 flag timer3, cipher, timer2 and radio, bits 3 to 0 read zero, reset zero.
// - The sleep timer pending flag is read-write bit 3 of the control register at index 0xd8, other bits read zero.
// - The enable register sits at index 0xe8 and its bit 7 is reserved and reads zero.
`timescale 1ns/1ps
module eip_ctrl #(
    parameter int NUM_SRC  = eip_pkg::NUM_SRC,
    parameter int SRC_ID_W = eip_pkg::SRC_ID_W
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [eip_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [eip_pkg::DATA_W-1:0]  pwdata,
    output logic      [eip_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Source events, one-cycle pulses in enable layout
    input  wire logic [NUM_SRC-1:0]          src_event,
    // Request towards the core
    output logic                             core_irq_req,
    output logic                             core_irq_high,
    output logic      [SRC_ID_W-1:0]         core_irq_src,
    // Interrupt line
    output logic                             irq
);

    typedef struct packed {
        logic [7:0]                 enable;
        logic [7:0]                 prio;
        logic [7:0]                 pending;
        logic [7:0]                 control;
        logic [7:0]                 aux;
        logic [7:0]                 irq_stat;
        logic [7:0]                 irq_mask;
        logic [eip_pkg::DATA_W-1:0] rdata;
        logic                       ready;
        logic                       slverr;
        logic                       req;
        logic                       req_high;
        logic [SRC_ID_W-1:0]        req_src;
        logic                       irq;
    } eip_state_type;

    eip_state_type state_ff;
    eip_state_type nxt_state;

    logic [NUM_SRC-1:0]          pend_vec;
    logic                        arb_req;
    logic                        arb_high;
    logic [SRC_ID_W-1:0]         arb_src;
    logic [eip_pkg::IDX_W-1:0]   idx;
    logic                        setup;
    logic                        wr;

    function automatic logic [eip_pkg::IDX_W-1:0] reg_index(
        input logic [eip_pkg::ADDR_W-1:0] addr);
        return addr[eip_pkg::ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [eip_pkg::IDX_W-1:0] i);
        logic hit;
        hit = 1'b0;
        case (i)
            eip_pkg::IDX_PENDING,
            eip_pkg::IDX_CONTROL,
            eip_pkg::IDX_ENABLE,
            eip_pkg::IDX_PRIORITY,
            eip_pkg::IDX_AUX_PEND,
            eip_pkg::IDX_IRQ_STAT,
            eip_pkg::IDX_IRQ_MASK: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // Gather the pending flags into enable layout
    function automatic logic [NUM_SRC-1:0] gather_pending(
        input logic [7:0] pend,
        input logic [7:0] ctl,
        input logic [7:0] aux);
        logic [NUM_SRC-1:0] v;
        v                     = '0;
        v[eip_pkg::SRC_VOICE]  = aux[eip_pkg::AUX_VOICE];
        v[eip_pkg::SRC_SPI]    = aux[eip_pkg::AUX_SPI];
        v[eip_pkg::SRC_SLEEP]  = ctl[eip_pkg::CTL_SLEEP];
        v[eip_pkg::SRC_TIMER3] = pend[eip_pkg::PEND_TIMER3];
        v[eip_pkg::SRC_CIPHER] = pend[eip_pkg::PEND_CIPHER];
        v[eip_pkg::SRC_TIMER2] = pend[eip_pkg::PEND_TIMER2];
        v[eip_pkg::SRC_RADIO]  = pend[eip_pkg::PEND_RADIO];
        return v;
    endfunction

    assign pend_vec = gather_pending(state_ff.pending, state_ff.control, state_ff.aux);
    assign idx      = reg_index(paddr);
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite & state_ff.ready;

    eip_arbiter #(
        .NUM_SRC  (NUM_SRC),
        .SRC_ID_W (SRC_ID_W)
    ) u_arbiter (
        .pending       (pend_vec),
        .enable        (state_ff.enable[NUM_SRC-1:0]),
        .priority_high (state_ff.prio[NUM_SRC-1:0]),
        .req           (arb_req),
        .req_high      (arb_high),
        .req_src       (arb_src)
    );

    always_comb begin
        nxt_state = state_ff;

        // No wait state; ready and read data are flopped in the setup cycle
        nxt_state.ready = setup;
        if (setup) begin
            nxt_state.slverr = ~is_mapped(idx);
            nxt_state.rdata  = '0;
            case (idx)
                eip_pkg::IDX_PENDING: begin
                    nxt_state.rdata[7:0] = state_ff.pending & eip_pkg::PENDING_MASK;
                end
                eip_pkg::IDX_CONTROL: begin
                    nxt_state.rdata[7:0] = state_ff.control & eip_pkg::CONTROL_MASK;
                end
                eip_pkg::IDX_ENABLE: begin
                    nxt_state.rdata[7:0] = state_ff.enable & eip_pkg::ENABLE_MASK;
                end
                eip_pkg::IDX_PRIORITY: begin
                    nxt_state.rdata[7:0] = state_ff.prio & eip_pkg::PRIORITY_MASK;
                end
                eip_pkg::IDX_AUX_PEND: begin
                    nxt_state.rdata[7:0] = state_ff.aux & eip_pkg::AUX_MASK;
                end
                eip_pkg::IDX_IRQ_STAT: begin
                    nxt_state.rdata[7:0] = state_ff.irq_stat & eip_pkg::IRQ_MASK_BITS;
                end
                eip_pkg::IDX_IRQ_MASK: begin
                    nxt_state.rdata[7:0] = state_ff.irq_mask & eip_pkg::IRQ_MASK_BITS;
                end
                default: begin
                    nxt_state.rdata = '0;
                end
            endcase
        end else if (state_ff.ready) begin
            nxt_state.slverr = 1'b0;
        end

        if (wr && idx == eip_pkg::IDX_ENABLE) begin
            nxt_state.enable = pwdata[7:0] & eip_pkg::ENABLE_MASK;
        end
        if (wr && idx == eip_pkg::IDX_PRIORITY) begin
            nxt_state.prio = pwdata[7:0] & eip_pkg::PRIORITY_MASK;
        end
        if (wr && idx == eip_pkg::IDX_IRQ_MASK) begin
            nxt_state.irq_mask = pwdata[7:0] & eip_pkg::IRQ_MASK_BITS;
        end

        if (wr && idx == eip_pkg::IDX_PENDING) begin
            nxt_state.pending = pwdata[7:0] & eip_pkg::PENDING_MASK;
        end
        if (wr && idx == eip_pkg::IDX_CONTROL) begin
            nxt_state.control = pwdata[7:0] & eip_pkg::CONTROL_MASK;
        end
        if (wr && idx == eip_pkg::IDX_AUX_PEND) begin
            nxt_state.aux = pwdata[7:0] & eip_pkg::AUX_MASK;
        end

        // events set flags, winning over a clearing write
        if (src_event[eip_pkg::SRC_TIMER3]) begin
            nxt_state.pending[eip_pkg::PEND_TIMER3] = 1'b1;
        end
        if (src_event[eip_pkg::SRC_CIPHER]) begin
            nxt_state.pending[eip_pkg::PEND_CIPHER] = 1'b1;
        end
        if (src_event[eip_pkg::SRC_TIMER2]) begin
            nxt_state.pending[eip_pkg::PEND_TIMER2] = 1'b1;
        end
        if (src_event[eip_pkg::SRC_RADIO]) begin
            nxt_state.pending[eip_pkg::PEND_RADIO] = 1'b1;
        end
        if (src_event[eip_pkg::SRC_SLEEP]) begin
            nxt_state.control[eip_pkg::CTL_SLEEP] = 1'b1;
        end
        if (src_event[eip_pkg::SRC_VOICE]) begin
            nxt_state.aux[eip_pkg::AUX_VOICE] = 1'b1;
        end
        if (src_event[eip_pkg::SRC_SPI]) begin
            nxt_state.aux[eip_pkg::AUX_SPI] = 1'b1;
        end

        // Sticky status, write one to clear, event wins
        if (wr && idx == eip_pkg::IDX_IRQ_STAT) begin
            nxt_state.irq_stat = state_ff.irq_stat & ~(pwdata[7:0] & eip_pkg::IRQ_MASK_BITS);
        end
        nxt_state.irq_stat[NUM_SRC-1:0] = nxt_state.irq_stat[NUM_SRC-1:0] | src_event;

        nxt_state.irq = |(state_ff.irq_stat & state_ff.irq_mask);

        nxt_state.req      = arb_req;
        nxt_state.req_high = arb_high;
        nxt_state.req_src  = arb_src;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff.enable   <= eip_pkg::ENABLE_RST;
            state_ff.prio     <= eip_pkg::PRIORITY_RST;
            state_ff.pending  <= eip_pkg::PENDING_RST;
            state_ff.control  <= eip_pkg::CONTROL_RST;
            state_ff.aux      <= eip_pkg::AUX_RST;
            state_ff.irq_stat <= eip_pkg::IRQ_STAT_RST;
            state_ff.irq_mask <= eip_pkg::IRQ_MASK_RST;
            state_ff.rdata    <= '0;
            state_ff.ready    <= 1'b0;
            state_ff.slverr   <= 1'b0;
            state_ff.req      <= 1'b0;
            state_ff.req_high <= 1'b0;
            state_ff.req_src  <= '0;
            state_ff.irq      <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata        = state_ff.rdata;
    assign pready        = state_ff.ready;
    assign pslverr       = state_ff.slverr;
    assign core_irq_req  = state_ff.req;
    assign core_irq_high = state_ff.req_high;
    assign core_irq_src  = state_ff.req_src;
    assign irq           = state_ff.irq;

endmodule

// ---- dv/eip_src_model.sv ----
`timescale 1ns/1ps
module eip_src_model (
    // Clock
    input wire logic   pclk,
    // Event pulses towards the block
    output logic [6:0] src_event
);
    initial src_event = '0;
    // One-cycle pulse on every source in the mask
    task automatic fire(input logic [6:0] m);
        @(posedge pclk);
        src_event <= m;
        @(posedge pclk);
        src_event <= '0;
    endtask
endmodule

// ---- dv/eip_ctrl_props.sv ----
`timescale 1ns/1ps
module eip_ctrl_props #(
    parameter int NUM_SRC  = 7,
    parameter int SRC_ID_W = 3
) (
    // Clock, reset and bus
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [eip_pkg::ADDR_W-1:0]   paddr,
    input wire logic [eip_pkg::DATA_W-1:0]   prdata,
    input wire logic                         pready,
    // Sources and requests
    input wire logic [NUM_SRC-1:0]           src_event,
    input wire logic                         core_irq_req,
    input wire logic                         core_irq_high,
    input wire logic [SRC_ID_W-1:0]          core_irq_src,
    input wire logic                         irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       rd_ack;
    logic       wr_acc;
    logic [9:0] idx;
    assign rd_ack = pready && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    assign idx    = paddr[11:2];

    a_pend_rsv_zero:
        assert property (rd_ack && idx == eip_pkg::IDX_PENDING |-> prdata[3:0] == 4'h0)
        else $error("pending reserved bits not zero");
    a_ctl_rsv_zero:
        assert property (rd_ack && idx == eip_pkg::IDX_CONTROL |-> (prdata & ~32'h08) == 0)
        else $error("control reserved bits not zero");
    a_en_rsv_zero:
        assert property (rd_ack && idx == eip_pkg::IDX_ENABLE |-> prdata[31:7] == 0)
        else $error("enable bit 7 not zero");
    a_pri_rsv_zero:
        assert property (rd_ack && idx == eip_pkg::IDX_PRIORITY |-> prdata[31:7] == 0)
        else $error("priority bit 7 not zero");
    a_high_needs_req:
        assert property (core_irq_high |-> core_irq_req)
        else $error("high level without request");
    a_src_in_range:
        assert property (core_irq_req |-> core_irq_src <= 3'd6)
        else $error("request source out of range");
    a_req_has_cause:
        assert property ($rose(core_irq_req) |-> $past(|src_event, 2) || $past(wr_acc, 2))
        else $error("request rose without event or write");
    a_req_stays_set:
        assert property ($fell(core_irq_req) |-> $past(wr_acc, 2))
        else $error("request fell without a write");
    a_irq_has_cause:
        assert property ($rose(irq) |-> $past(|src_event, 2) || $past(wr_acc, 2))
        else $error("interrupt rose without cause");

    c_high_req: cover property (core_irq_req && core_irq_high);
    c_irq_up: cover property (irq);
    c_low_req: cover property (core_irq_req && !core_irq_high);
endmodule

bind eip_ctrl eip_ctrl_props #(.NUM_SRC(NUM_SRC), .SRC_ID_W(SRC_ID_W)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .src_event(src_event),
    .core_irq_req(core_irq_req), .core_irq_high(core_irq_high),
    .core_irq_src(core_irq_src), .irq(irq));

// ---- dv/eip_ctrl_tb.sv ----
`timescale 1ns/1ps
module eip_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        core_irq_req, core_irq_high, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  src_event;
    logic [2:0]  core_irq_src;
    int          error_cnt, n_checks;
    // Flag home of each source, enable bit order
    logic [9:0]  f_idx [7] = '{eip_pkg::IDX_PENDING, eip_pkg::IDX_PENDING, eip_pkg::IDX_PENDING,
        eip_pkg::IDX_PENDING, eip_pkg::IDX_CONTROL, eip_pkg::IDX_AUX_PEND, eip_pkg::IDX_AUX_PEND};
    int          f_bit [7] = '{4, 5, 6, 7, 3, 0, 1};
    logic [9:0]  all_idx [7] = '{eip_pkg::IDX_PENDING, eip_pkg::IDX_CONTROL, eip_pkg::IDX_ENABLE,
        eip_pkg::IDX_PRIORITY, eip_pkg::IDX_AUX_PEND, eip_pkg::IDX_IRQ_STAT, eip_pkg::IDX_IRQ_MASK};

    eip_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_event(src_event), .core_irq_req(core_irq_req),
        .core_irq_high(core_irq_high), .core_irq_src(core_irq_src), .irq(irq));
    eip_src_model src (.pclk(pclk), .src_event(src_event));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic apb(input logic [9:0] i, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [9:0] i, input logic [7:0] e);
        apb(i, 1'b0, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    // Request outputs after their one-cycle lag
    task automatic core(input logic [4:0] e);
        repeat (2) @(posedge pclk);
        chk({27'h0, core_irq_req, core_irq_high, core_irq_src}, {27'h0, e});
    endtask

    task automatic t_reset;
        foreach (all_idx[i]) rdchk(all_idx[i], 8'h00);
    endtask
    task automatic t_regs;
        apb(eip_pkg::IDX_ENABLE, 1'b1, 8'hff);
        rdchk(eip_pkg::IDX_ENABLE, 8'h7f);
        apb(eip_pkg::IDX_PRIORITY, 1'b1, 8'hff);
        rdchk(eip_pkg::IDX_PRIORITY, 8'h7f);
        apb(eip_pkg::IDX_PENDING, 1'b1, 8'hff);
        rdchk(eip_pkg::IDX_PENDING, 8'hf0);
        apb(eip_pkg::IDX_CONTROL, 1'b1, 8'hff);
        rdchk(eip_pkg::IDX_CONTROL, 8'h08);
        for (int i = 0; i < 4; i++) apb(all_idx[i], 1'b1, 8'h00);
        apb(10'h3ff, 1'b0, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_events;
        for (int i = 0; i < 7; i++) begin
            src.fire(7'h01 << i);
            core(5'h00);
            rdchk(f_idx[i], 8'h01 << f_bit[i]);
            apb(eip_pkg::IDX_ENABLE, 1'b1, 8'h01 << i);
            core({2'b10, i[2:0]});
            rdchk(f_idx[i], 8'h01 << f_bit[i]);
            apb(f_idx[i], 1'b1, 8'h00);
            core(5'h00);
        end
        apb(eip_pkg::IDX_ENABLE, 1'b1, 8'h00);
        apb(eip_pkg::IDX_IRQ_STAT, 1'b1, 8'h7f);
    endtask
    task automatic t_priority;
        src.fire(7'h41);
        apb(eip_pkg::IDX_ENABLE, 1'b1, 8'h41);
        apb(eip_pkg::IDX_PRIORITY, 1'b1, 8'h40);
        core(5'h1e);
        apb(eip_pkg::IDX_PRIORITY, 1'b1, 8'h00);
        core(5'h10);
        apb(eip_pkg::IDX_PRIORITY, 1'b1, 8'h01);
        core(5'h18);
        for (int i = 0; i < 6; i++) apb(all_idx[i], 1'b1, 8'h00);
        // Status bits are write-one-to-clear
        apb(eip_pkg::IDX_IRQ_STAT, 1'b1, 8'h7f);
    endtask
    task automatic t_irq;
        apb(eip_pkg::IDX_IRQ_MASK, 1'b1, 8'h08);
        src.fire(7'h08);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(eip_pkg::IDX_IRQ_MASK, 1'b1, 8'h00);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(eip_pkg::IDX_IRQ_MASK, 1'b1, 8'h08);
        rdchk(eip_pkg::IDX_IRQ_STAT, 8'h08);
        apb(eip_pkg::IDX_IRQ_STAT, 1'b1, 8'h08);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(eip_pkg::IDX_PENDING, 8'h80);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_events();
        t_priority();
        t_irq();
        end_of_test();
    end
endmodule
